/* File: hw/dapd_pkg.sv */
package dapd_pkg;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam int unsigned DAPD_ADDR_W = 4;
  localparam logic [DAPD_ADDR_W-1:0] DAPD_OFS_CTRL = 4'h0;
  localparam logic [DAPD_ADDR_W-1:0] DAPD_OFS_STATUS = 4'h4;
  localparam logic [DAPD_ADDR_W-1:0] DAPD_OFS_INPUTS = 4'h8;
  localparam logic [DAPD_ADDR_W-1:0] DAPD_OFS_FEATURE = 4'hC;

  // ---------------------------------------------------------------
  // Field layout
  // ---------------------------------------------------------------
  localparam int unsigned DAPD_CTRL_W = 3;
  localparam int unsigned DAPD_CTRL_ROOT_HOLD = 0;
  localparam int unsigned DAPD_CTRL_REALM_HOLD = 1;
  localparam int unsigned DAPD_CTRL_LEGACY_HOLD = 2;
  localparam logic [DAPD_CTRL_W-1:0] DAPD_CTRL_RESET = 3'h7;
  localparam int unsigned DAPD_STAT_HELD_ROOT = 8;
  localparam int unsigned DAPD_STAT_HELD_REALM = 9;
  localparam int unsigned DAPD_STAT_HELD_LEGACY = 10;
  localparam int unsigned DAPD_STAT_CAPTURED = 11;
  localparam int unsigned DAPD_STAT_LEGACY_EFF = 12;
  // Secure, hypervisor, root/realm support; realm stays reported in legacy mode
  localparam logic [31:0] DAPD_FEATURE_VAL = 32'h0000_0007;

  // ---------------------------------------------------------------
  // Bus answers and timing
  // ---------------------------------------------------------------
  localparam logic [1:0] DAPD_RESP_OKAY = 2'h0;
  localparam logic [1:0] DAPD_RESP_SLVERR = 2'h2;
  localparam int unsigned DAPD_PERM_LATENCY = 2;

  // ---------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic legacy_security_mode;
    logic root_invasive_enable;
    logic realm_invasive_enable;
    logic hyp_noninvasive_enable;
    logic hyp_invasive_enable;
    logic secure_noninvasive_enable;
    logic secure_invasive_enable;
    logic noninvasive_enable;
    logic invasive_enable;
  } dapd_auth_in_t;

  typedef struct packed {
    logic root_inv;
    logic realm_inv;
    logic hyp_noninv;
    logic hyp_inv;
    logic sec_noninv;
    logic sec_inv;
    logic ns_noninv;
    logic ns_inv;
  } dapd_perm_t;

endpackage

/* File: hw/dapd_auth_decode.sv */
// Behaviour
// R1 - NS invasive follows invasive_enable; NS non-invasive is invasive OR non-invasive enable.
// R2 - Secure invasive needs both invasive enables; secure non-invasive needs secure and NS terms.
// R3 - Hypervisor invasive is hyp_invasive_enable AND invasive_enable.
// R4 - Hypervisor non-invasive needs a hypervisor enable and a non-hypervisor enable.
// R5 - Root invasive needs invasive, realm, secure and root invasive enables all high.
// R6 - Realm invasive is invasive AND realm enables; no root/realm non-invasive output.
// R7 - Secure outputs ignore hypervisor enables, hypervisor outputs ignore secure enables.
// R8 - Driver avoids secure or non-invasive enable combinations that are invalid.
// R9 - Driver must not use the deprecated secure non-invasive combinations.
// R10 - Driver avoids invalid hypervisor combinations; device still decodes them by equation.
// R11 - System changes root enable effect only during the system reset.
// R12 - System captures root enable on leaving reset and distributes it steadily.
// R13 - Device may sample root enable only when its own reset releases; with DAPD_CTRL_ROOT_HOLD cleared the device uses the sampled live input.
// R14 - System keeps realm enable effect fixed after root firmware is loaded.
// R15 - System samples realm enable at reset, resampling only when root firmware allows.
// R16 - Device may sample realm enable at reset release, then ignore later changes; with DAPD_CTRL_REALM_HOLD cleared the device follows later changes.
// R17 - System orders resets so components capture the fixed root and realm values.
// R18 - Device has a legacy_security_mode input selecting realm management on or off.
// R19 - Legacy mode ignores root and realm enables and forces those permissions off.
// R20 - Device still reports realm management support while legacy mode is set.
// R21 - System keeps legacy_security_mode constant after the system reset releases.
// R22 - Device captures legacy_security_mode at its own reset release and holds it; with DAPD_CTRL_LEGACY_HOLD cleared the device uses the live input.
// R23 - All authentication inputs sampled on the rising edge of the auth clock.
// R24 - Input-to-permission latency is fixed by the design and documented.
// R25 - Permission outputs registered, and cleared to not permitted during reset.
`timescale 1ns/1ps
module dapd_auth_decode
  import dapd_pkg::*;
#(
  parameter logic [31:0] FEATURE_VAL = DAPD_FEATURE_VAL
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire dapd_auth_in_t auth_in,
  output dapd_perm_t perm,
  input wire logic [DAPD_ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [DAPD_ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    dapd_auth_in_t smp;
    logic cap_pend;
    logic held_root;
    logic held_realm;
    logic held_legacy;
    logic [DAPD_CTRL_W-1:0] ctrl;
    dapd_perm_t perm;
    logic awready;
    logic aw_full;
    logic [DAPD_ADDR_W-1:0] awaddr;
    logic wready;
    logic w_full;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } dapd_state_t;

  dapd_state_t state_reg;
  dapd_state_t state_next;

  // ---------------------------------------------------------------
  // Permission equations
  // ---------------------------------------------------------------
  function automatic dapd_perm_t decode_perm(
    input dapd_auth_in_t a,
    input logic root_en,
    input logic realm_en
  );
    dapd_perm_t p;
    p.ns_inv = a.invasive_enable; // R1
    p.ns_noninv = a.invasive_enable | a.noninvasive_enable; // R1
    // Secure terms draw on no hypervisor enable
    p.sec_inv = a.invasive_enable & a.secure_invasive_enable; // R2 R7
    p.sec_noninv = (a.secure_invasive_enable | a.secure_noninvasive_enable) &
                   (a.invasive_enable | a.noninvasive_enable); // R2 R7
    // Hypervisor terms draw on no secure enable
    p.hyp_inv = a.hyp_invasive_enable & a.invasive_enable; // R3 R7
    p.hyp_noninv = (a.hyp_invasive_enable | a.hyp_noninvasive_enable) &
                   (a.invasive_enable | a.noninvasive_enable); // R4 R10
    p.root_inv = a.invasive_enable & realm_en & a.secure_invasive_enable &
                 root_en; // R5
    p.realm_inv = a.invasive_enable & realm_en; // R6
    return p;
  endfunction

  // ---------------------------------------------------------------
  // Register read mux
  // ---------------------------------------------------------------
  function automatic logic [32:0] read_word(
    input logic [DAPD_ADDR_W-1:0] addr,
    input dapd_state_t s,
    input logic legacy_eff,
    input logic [31:0] feature
  );
    logic [32:0] r;
    r = {1'b0, 32'h0000_0000};
    unique case (addr)
      DAPD_OFS_CTRL: begin
        r[DAPD_CTRL_W-1:0] = s.ctrl;
      end
      DAPD_OFS_STATUS: begin
        r[7:0] = s.perm;
        r[DAPD_STAT_HELD_ROOT] = s.held_root;
        r[DAPD_STAT_HELD_REALM] = s.held_realm;
        r[DAPD_STAT_HELD_LEGACY] = s.held_legacy;
        r[DAPD_STAT_CAPTURED] = ~s.cap_pend;
        r[DAPD_STAT_LEGACY_EFF] = legacy_eff;
      end
      DAPD_OFS_INPUTS: begin
        r[8:0] = s.smp;
      end
      DAPD_OFS_FEATURE: begin
        r[31:0] = feature; // R20
      end
      default: begin
        r[32] = 1'b1;
      end
    endcase
    return r;
  endfunction

  // ---------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------
  logic eff_legacy;
  logic eff_root;
  logic eff_realm;
  logic [32:0] rd_word;

  always_comb begin
    state_next = state_reg;

    // Enables are taken on every edge with ce high
    state_next.smp = auth_in; // R23

    // Capture of root, realm and legacy strap at reset release
    if (state_reg.cap_pend) begin
      state_next.held_root = auth_in.root_invasive_enable; // R13 R17
      state_next.held_realm = auth_in.realm_invasive_enable; // R16 R17
      state_next.held_legacy = auth_in.legacy_security_mode; // R22
      state_next.cap_pend = 1'b0;
    end

    // Held values ignore later input changes until the next reset
    eff_legacy = state_reg.ctrl[DAPD_CTRL_LEGACY_HOLD] ?
                 state_reg.held_legacy :
                 state_reg.smp.legacy_security_mode; // R18 R22
    eff_root = state_reg.ctrl[DAPD_CTRL_ROOT_HOLD] ?
               state_reg.held_root :
               state_reg.smp.root_invasive_enable; // R13
    eff_realm = state_reg.ctrl[DAPD_CTRL_REALM_HOLD] ?
                state_reg.held_realm :
                state_reg.smp.realm_invasive_enable; // R16
    // Legacy mode masks both root and realm enables
    eff_root = eff_root & ~eff_legacy; // R19
    eff_realm = eff_realm & ~eff_legacy; // R19
    // Nothing is granted before the capture has happened
    if (state_reg.cap_pend) begin
      eff_root = 1'b0;
      eff_realm = 1'b0;
    end

    // Second stage: registered permissions
    state_next.perm = decode_perm(state_reg.smp, eff_root, eff_realm); // R24 R25

    // Write address and data, taken in either order
    if (s_axi_awvalid && state_reg.awready) begin
      state_next.aw_full = 1'b1;
      state_next.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && state_reg.wready) begin
      state_next.w_full = 1'b1;
      state_next.wdata = s_axi_wdata;
      state_next.wstrb = s_axi_wstrb;
    end
    // Response once both halves are held
    if (state_next.aw_full && state_next.w_full && !state_reg.bvalid) begin
      state_next.aw_full = 1'b0;
      state_next.w_full = 1'b0;
      state_next.bvalid = 1'b1;
      state_next.bresp = DAPD_RESP_OKAY;
      unique case (state_next.awaddr)
        DAPD_OFS_CTRL: begin
          if (state_next.wstrb[0]) begin
            state_next.ctrl = state_next.wdata[DAPD_CTRL_W-1:0];
          end
        end
        DAPD_OFS_STATUS, DAPD_OFS_INPUTS, DAPD_OFS_FEATURE: begin
          // Read-only words accept and drop the write
          state_next.bresp = DAPD_RESP_OKAY;
        end
        default: begin
          state_next.bresp = DAPD_RESP_SLVERR;
        end
      endcase
    end
    if (state_reg.bvalid && s_axi_bready) begin
      state_next.bvalid = 1'b0;
    end
    state_next.awready = !state_next.aw_full && !state_next.bvalid;
    state_next.wready = !state_next.w_full && !state_next.bvalid;

    // Read channel, one outstanding
    rd_word = read_word(s_axi_araddr, state_reg, eff_legacy, FEATURE_VAL);
    if (s_axi_arvalid && state_reg.arready) begin
      state_next.rvalid = 1'b1;
      state_next.rdata = rd_word[31:0];
      state_next.rresp = rd_word[32] ? DAPD_RESP_SLVERR : DAPD_RESP_OKAY;
    end
    if (state_reg.rvalid && s_axi_rready) begin
      state_next.rvalid = 1'b0;
    end
    state_next.arready = !state_next.rvalid;
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= '0; // R25
      state_reg.cap_pend <= 1'b1;
      state_reg.ctrl <= DAPD_CTRL_RESET;
      state_reg.bresp <= DAPD_RESP_OKAY;
      state_reg.rresp <= DAPD_RESP_OKAY;
    end else if (ce) begin
      state_reg <= state_next;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign perm = state_reg.perm;
  assign s_axi_awready = state_reg.awready;
  assign s_axi_wready = state_reg.wready;
  assign s_axi_bvalid = state_reg.bvalid;
  assign s_axi_bresp = state_reg.bresp;
  assign s_axi_arready = state_reg.arready;
  assign s_axi_rvalid = state_reg.rvalid;
  assign s_axi_rdata = state_reg.rdata;
  assign s_axi_rresp = state_reg.rresp;

endmodule

/* File: dv/dapd_auth_decode_monitor.sv */
`timescale 1ns/1ps
module dapd_auth_decode_monitor
  import dapd_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire dapd_auth_in_t auth_in,
  input wire dapd_perm_t perm,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid
);
  dapd_auth_in_t d1;
  dapd_auth_in_t d2;
  dapd_auth_in_t hold;
  logic [1:0] rcnt;
  logic up;
  // ------------------------------------------------
  // Input echo two edges back, capture at release
  // ------------------------------------------------
  always_ff @(posedge aclk) begin
    if (ce) begin
      d1 <= auth_in;
      d2 <= d1;
    end
    if (!aresetn) begin
      rcnt <= 2'h0;
    end else if (ce) begin
      if (rcnt == 2'h0) hold <= auth_in;
      if (rcnt != 2'h3) rcnt <= rcnt + 2'h1;
    end
  end
  assign up = rcnt == 2'h3;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  chk_ns_perm: assert property (up |-> perm.ns_inv == d2[0]
    && perm.ns_noninv == (d2[0] | d2[1])) else $error("ns permission wrong");
  chk_sec_perm: assert property (up |-> perm.sec_inv == (d2[0] & d2[2])
    && perm.sec_noninv == ((d2[2] | d2[3]) & (d2[0] | d2[1])))
    else $error("secure permission wrong");
  chk_hyp_inv: assert property (up |-> perm.hyp_inv == (d2[4] & d2[0]))
    else $error("hyp invasive wrong");
  chk_hyp_noninv: assert property (up |->
    perm.hyp_noninv == ((d2[4] | d2[5]) & (d2[0] | d2[1]))) else $error("hyp noninv wrong");
  chk_root_perm: assert property (up |->
    perm.root_inv == (d2[0] & d2[2] & hold[6] & hold[7] & !hold[8])) else $error("root wrong");
  chk_realm_perm: assert property (up |->
    perm.realm_inv == (d2[0] & hold[6] & !hold[8])) else $error("realm wrong");
  chk_reset_clear: assert property (disable iff (1'h0) !aresetn |=> perm == '0)
    else $error("perm not cleared in reset");
  chk_b_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |=> s_axi_bvalid ##1 !s_axi_bvalid) else $error("write answer late");
  chk_aw_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while answer pending");
  chk_r_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid
    && !s_axi_arready ##1 !s_axi_rvalid) else $error("read answer wrong");
  cov_root: cover property (up && perm.root_inv);
  cov_legacy: cover property (up && hold[8] && d2[0]);
  cov_read: cover property (s_axi_rvalid);
endmodule

bind dapd_auth_decode dapd_auth_decode_monitor u_mon (.aclk, .aresetn, .ce, .auth_in, .perm,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid);

/* File: dv/dapd_auth_src.sv */
`timescale 1ns/1ps
module dapd_auth_src
  import dapd_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic rogue,
  input wire dapd_auth_in_t nxt,
  output dapd_auth_in_t auth_in
);
  // ------------------------------------------------
  // Enables follow requests; reset-time ones move only in reset or while rogue is set
  // ------------------------------------------------
  always_ff @(posedge aclk) begin
    auth_in[5:0] <= nxt[5:0];
    if (!aresetn || rogue) auth_in[8:6] <= nxt[8:6];
  end
endmodule

/* File: dv/dapd_auth_decode_tb.sv */
`timescale 1ns/1ps
module dapd_auth_decode_tb;
  import dapd_pkg::*;
  typedef struct packed {logic [31:0] d; logic [31:0] m; logic [1:0] r;} dapd_exp_t;
  logic aclk = 0, aresetn = 0, rogue = 0, ce = 1, awvalid = 0, wvalid = 0, bready = 0;
  logic arvalid = 0, rready = 0, bvalid, rvalid, awready, wready, arready;
  logic [3:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata, seed = 32'hFB91;
  logic [1:0] bresp, rresp;
  logic [2:0] held;
  logic [8:0] pick;
  dapd_auth_in_t nxt = '0, pins, exp_in;
  dapd_perm_t perm;
  dapd_exp_t e;
  dapd_exp_t rq[$];
  logic [1:0] bq[$];
  int err_count = 0, compares = 0;
  always #10 aclk = ~aclk;
  dapd_auth_src u_src (.aclk, .aresetn, .rogue, .nxt, .auth_in(pins));
  dapd_auth_decode DUT (.aclk, .aresetn, .ce, .auth_in(pins), .perm,
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  // ------------------------------------------------
  // Helpers
  // ------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  function automatic dapd_perm_t model(input dapd_auth_in_t a, input logic [2:0] h);
    dapd_perm_t p;
    p.ns_inv = a[0];
    p.ns_noninv = a[0] | a[1];
    p.sec_inv = a[0] & a[2];
    p.sec_noninv = (a[2] | a[3]) & p.ns_noninv;
    p.hyp_inv = a[4] & a[0];
    p.hyp_noninv = (a[4] | a[5]) & p.ns_noninv;
    p.realm_inv = a[0] & h[0] & !h[2];
    p.root_inv = p.realm_inv & a[2] & h[1];
    return p;
  endfunction
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
    @(posedge aclk);
    bq.push_back(r);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
    end while (!bvalid);
    bready <= 1'h0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] d, input logic [31:0] m,
      input logic [1:0] r);
    @(posedge aclk);
    rq.push_back({d, m, r});
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'h0;
    end while (!rvalid);
    rready <= 1'h0;
  endtask
  task automatic wrap_up();
    $display("err_count %0d compares %0d", err_count, compares);
    if (err_count == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  always @(posedge aclk) begin
    if (bvalid && bready) cmp({30'h0, bresp}, {30'h0, bq.pop_front()}, "bresp");
    if (rvalid && rready) begin
      e = rq.pop_front();
      cmp(rdata & e.m, e.d & e.m, "rdata");
      cmp({30'h0, rresp}, {30'h0, e.r}, "rresp");
    end
  end
  initial begin
    #200000;
    err_count++;
    wrap_up();
  end
  // ------------------------------------------------
  // Reset rounds: root+realm, root only, legacy with live changes
  // ------------------------------------------------
  initial begin
    for (int k = 0; k < 3; k++) begin
      held = (k == 0) ? 3'h3 : (k == 1) ? 3'h2 : 3'h7;
      aresetn <= 1'h0;
      rogue <= 1'h0;
      nxt <= {held, 6'h3F};
      repeat (5) @(posedge aclk);
      aresetn <= 1'h1;
      rogue <= (k == 2);
      #1;
      cmp({24'h0, perm}, 32'h0, "reset perm");
      rd(DAPD_OFS_CTRL, 32'(DAPD_CTRL_RESET), 32'h7, DAPD_RESP_OKAY);
      rd(DAPD_OFS_FEATURE, DAPD_FEATURE_VAL, '1, DAPD_RESP_OKAY);
      wr(DAPD_OFS_STATUS, 32'hFFFF_FFFF, DAPD_RESP_OKAY);
      wr(4'h6, 32'h0, DAPD_RESP_SLVERR);
      rd(4'h6, 32'h0, '1, DAPD_RESP_SLVERR);
      wr(DAPD_OFS_CTRL, 32'h7, DAPD_RESP_OKAY);
      repeat (30) begin
        seed = xs(seed);
        pick = seed[8:0];
        if (pick[3] && !pick[0] && (!pick[1] || pick[2])) begin
          pick[3] = 1'h0;
        end
        @(posedge aclk);
        nxt <= pick;
        exp_in = rogue ? pick : {held, pick[5:0]};
        repeat (DAPD_PERM_LATENCY + 1) @(posedge aclk);
        #1;
        cmp({24'h0, perm}, {24'h0, model(exp_in, held)}, "perm");
        rd(DAPD_OFS_STATUS, {19'h0, held[2], 1'h1, held[2], held[0], held[1],
          model(exp_in, held)}, 32'h1FFF, DAPD_RESP_OKAY);
        rd(DAPD_OFS_INPUTS, {23'h0, exp_in}, 32'h1FF, DAPD_RESP_OKAY);
      end
      ce <= 1'h0;
      nxt <= {exp_in[8:6], {6{~exp_in[0]}}};
      repeat (4) @(posedge aclk);
      #1;
      cmp({24'h0, perm}, {24'h0, model(exp_in, held)}, "frozen perm");
      @(posedge aclk);
      ce <= 1'h1;
    end
    wrap_up();
  end
endmodule
